// File: bit_skip_clear_call_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"

// Summary of operation
// - Skip-if-set: bit one flushes next instruction
// - Skip-if-clear: bit zero flushes next instruction
// - Clear file register writes zero, sets zero
// - Clear accumulator loads zero, sets zero
// - Call pushes return address PC+1 first
// - Call loads literal into PC low bits
// - Call takes PC upper bits from latch
// - Call is two cycles, flags unchanged
// - Watchdog clear pulses watchdogClear for one cycle
// - Watchdog clear sets both status bits
module bit_skip_clear_call_exec
	import exec_pkg::*;
#(
	parameter int STACK_DEPTH = 8,
	parameter int STACK_AW = 3
)(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Instruction and operands, one per instruction cycle
	input wire logic instrValid,
	input wire logic [13:0] instr,
	input wire logic [7:0] fileRdData,
	input wire logic [7:0] pc_page_latch,
	// File register write
	output logic fileWrEn,
	output logic [6:0] fileWrAddr,
	output logic [7:0] fileWrData,
	// Core state
	output logic [12:0] pc,
	output logic [7:0] accum,
	output logic zeroFlag,
	output logic [12:0] stack_top,
	output logic [STACK_AW-1:0] stackPtr,
	// Watchdog side effects and flush indicator
	output logic watchdogClear,
	output logic timeout_status_n,
	output logic powerdown_status_n,
	output logic flushing
);
	// ************************************************************
	// Decode
	// ************************************************************
	logic isSkipClr, isSkipSet, isClrf, isClrw, isCall, isWdt;
	logic testBit, takeSkip;
	logic [2:0] bitSel;
	exec_state_e state, next_state;

	// Decode only while not flushing; a flushed slot is a no-op
	always_comb
	begin
		bitSel = instr[`FLD_BIT_LSB +: 3];
		testBit = fileRdData[bitSel];
		isSkipClr = instrValid && (state == ST_RUN)
			&& ((instr & `OPC_BIT_CLR_MASK) == `OPC_BIT_CLR_VAL);
		isSkipSet = instrValid && (state == ST_RUN)
			&& ((instr & `OPC_BIT_CLR_MASK) == `OPC_BIT_SET_VAL);
		isClrf = instrValid && (state == ST_RUN)
			&& ((instr & `OPC_CLEAR_FILE_REG_OP_MASK) == `OPC_CLEAR_FILE_REG_OP_VAL);
		isClrw = instrValid && (state == ST_RUN) && (instr == `OPC_CLEAR_ACCUM_OP_VAL);
		isCall = instrValid && (state == ST_RUN)
			&& ((instr & `OPC_CALL_MASK) == `OPC_CALL_VAL);
		isWdt = instrValid && (state == ST_RUN) && (instr == `OPC_WDTCLR_VAL);
		takeSkip = (isSkipSet && testBit) || (isSkipClr && !testBit);
	end

	// ************************************************************
	// Next-state and datapath
	// ************************************************************
	logic [12:0] next_pc;
	logic [7:0] next_accum;
	logic next_zeroFlag, next_fileWrEn, next_watchdogClear;
	logic next_timeout_status_n, next_powerdown_status_n;
	logic [6:0] next_fileWrAddr;
	logic [STACK_AW-1:0] next_stackPtr;
	logic pushEn;
	logic [12:0] pushData, stackRd;
	logic [12:0] next_stack_top;
	logic next_flushing;

	// A call or taken skip spends its second cycle flushing the fetched word
	always_comb
	begin
		next_state = ST_RUN;
		next_pc = pc;
		next_accum = accum;
		next_zeroFlag = zeroFlag;
		next_fileWrEn = 1'b0;
		next_fileWrAddr = fileWrAddr;
		next_watchdogClear = 1'b0;
		next_timeout_status_n = timeout_status_n;
		next_powerdown_status_n = powerdown_status_n;
		next_stackPtr = stackPtr;
		next_stack_top = stack_top;
		next_flushing = 1'b0;
		pushEn = 1'b0;
		pushData = pc + 13'h0001;
		if (instrValid)
		begin
			next_pc = pc + 13'h0001;
			if (takeSkip || isCall)
			begin
				next_state = ST_FLUSH;
				next_flushing = 1'b1;
			end
			if (isClrf)
			begin
				next_fileWrEn = 1'b1;
				next_fileWrAddr = instr[`FLD_FILE_LSB +: 7];
				next_zeroFlag = 1'b1;
			end
			if (isClrw)
			begin
				next_accum = `ACC_RESET;
				next_zeroFlag = 1'b1;
			end
			if (isCall)
			begin
				pushEn = 1'b1;
				next_stack_top = pushData;
				next_stackPtr = stackPtr + 1'b1;
				next_pc = {pc_page_latch[`PAGE_LATCH_HI:`PAGE_LATCH_LO],
					instr[10:0]};
			end
			if (isWdt)
			begin
				next_watchdogClear = 1'b1;
				next_timeout_status_n = 1'b1;
				next_powerdown_status_n = 1'b1;
			end
		end
	end

	// Register all state; outputs come straight from these flops
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state <= ST_RUN;
			pc <= `PC_RESET;
			accum <= `ACC_RESET;
			zeroFlag <= 1'b0;
			fileWrEn <= 1'b0;
			fileWrAddr <= 7'h00;
			fileWrData <= 8'h00;
			watchdogClear <= 1'b0;
			timeout_status_n <= `STATUS_N_RESET;
			powerdown_status_n <= `STATUS_N_RESET;
			stackPtr <= '0;
			stack_top <= `PC_RESET;
			flushing <= 1'b0;
		end
		else
		begin
			state <= next_state;
			pc <= next_pc;
			accum <= next_accum;
			zeroFlag <= next_zeroFlag;
			fileWrEn <= next_fileWrEn;
			fileWrAddr <= next_fileWrAddr;
			fileWrData <= 8'h00;
			watchdogClear <= next_watchdogClear;
			timeout_status_n <= next_timeout_status_n;
			powerdown_status_n <= next_powerdown_status_n;
			stackPtr <= next_stackPtr;
			stack_top <= next_stack_top;
			flushing <= next_flushing;
		end
	end

	// ************************************************************
	// Return-address stack
	// ************************************************************
	// Wraps silently on overflow, like a circular hardware stack
	// Read side looks one entry below the pointer, so the last push shows two cycles on
	stack_mem #(.DEPTH(STACK_DEPTH), .AW(STACK_AW)) stack_mem_inst (
		.core_clk(core_clk),
		.wrEn(pushEn),
		.wrAddr(stackPtr),
		.wrData(pushData),
		.rdAddr(stackPtr - 1'b1),
		.rdData(stackRd)
	);

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_skip_set;
		@(posedge core_clk) disable iff (!rst_n)
		(isSkipSet && testBit) |=> flushing;
	endproperty
	a_skip_set: assert property (p_skip_set) else $error("skip-if-set missed flush");

	property p_skip_clr;
		@(posedge core_clk) disable iff (!rst_n)
		(isSkipClr && !testBit) |=> flushing;
	endproperty
	a_skip_clr: assert property (p_skip_clr) else $error("skip-if-clear missed flush");

	property p_no_skip;
		@(posedge core_clk) disable iff (!rst_n)
		((isSkipSet && !testBit) || (isSkipClr && testBit)) |=> !flushing;
	endproperty
	a_no_skip: assert property (p_no_skip) else $error("skip taken wrongly");

	property p_clear_file_reg_op;
		@(posedge core_clk) disable iff (!rst_n)
		isClrf |=> fileWrEn && fileWrData == 8'h00 && zeroFlag
			&& fileWrAddr == $past(instr[6:0]);
	endproperty
	a_clear_file_reg_op: assert property (p_clear_file_reg_op) else $error("clear file register wrong");

	property p_clear_accum_op;
		@(posedge core_clk) disable iff (!rst_n)
		isClrw |=> accum == 8'h00 && zeroFlag;
	endproperty
	a_clear_accum_op: assert property (p_clear_accum_op) else $error("clear accumulator wrong");

	property p_call_push;
		@(posedge core_clk) disable iff (!rst_n)
		isCall |=> stack_top == $past(pc) + 13'h0001 && stackPtr == $past(stackPtr) + 1'b1;
	endproperty
	a_call_push: assert property (p_call_push) else $error("call push wrong");

	// The flush slot after a call cannot push, so the entry is settled two cycles on
	property p_stack_rd;
		@(posedge core_clk) disable iff (!rst_n)
		isCall |=> ##1 stackRd == stack_top;
	endproperty
	a_stack_rd: assert property (p_stack_rd) else $error("stack memory entry wrong");

	property p_call_target;
		@(posedge core_clk) disable iff (!rst_n)
		isCall |=> pc == {$past(pc_page_latch[4:3]), $past(instr[10:0])};
	endproperty
	a_call_target: assert property (p_call_target) else $error("call target wrong");

	property p_call_flags;
		@(posedge core_clk) disable iff (!rst_n)
		isCall |=> flushing && $stable(zeroFlag) && $stable(timeout_status_n);
	endproperty
	a_call_flags: assert property (p_call_flags) else $error("call cycles or flags wrong");

	property p_wdt;
		@(posedge core_clk) disable iff (!rst_n)
		isWdt |=> watchdogClear && timeout_status_n && powerdown_status_n
			##1 (watchdogClear == $past(isWdt));
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");

	property p_flush_nop;
		@(posedge core_clk) disable iff (!rst_n)
		(state == ST_FLUSH && instrValid) |=> !fileWrEn && $stable(accum) && $stable(zeroFlag)
			&& $stable(stackPtr) && pc == $past(pc) + 13'h0001;
	endproperty
	a_flush_nop: assert property (p_flush_nop) else $error("flush slot altered state");
endmodule
`default_nettype wire

// File: exec_cfg.svh
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// Opcode encodings of the 14-bit instruction word
`define OPC_BIT_CLR_MASK 14'h3C00
`define OPC_BIT_CLR_VAL 14'h1800
`define OPC_BIT_SET_VAL 14'h1C00
`define OPC_CLEAR_FILE_REG_OP_MASK 14'h3F80
`define OPC_CLEAR_FILE_REG_OP_VAL 14'h0180
`define OPC_CLEAR_ACCUM_OP_VAL 14'h0100
`define OPC_CALL_MASK 14'h3800
`define OPC_CALL_VAL 14'h2000
`define OPC_WDTCLR_VAL 14'h0064

// Field positions
`define FLD_FILE_LSB 0
`define FLD_BIT_LSB 7
`define PAGE_LATCH_LO 3
`define PAGE_LATCH_HI 4

// Reset values
`define PC_RESET 13'h0000
`define ACC_RESET 8'h00
`define STATUS_N_RESET 1'b1

`endif

// File: exec_pkg.sv
`default_nettype none

package exec_pkg;
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_FLUSH = 2'b01
	} exec_state_e;
	typedef logic [12:0] pc_t;
endpackage

`default_nettype wire

// File: stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"

// Return-address memory with registered top-of-stack read
module stack_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
)(
	// Clock
	input wire logic core_clk,
	// Write port
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [12:0] wrData,
	// Read port
	input wire logic [AW-1:0] rdAddr,
	output logic [12:0] rdData
);
	logic [12:0] mem [DEPTH];

	// No reset on the array: contents are undefined until pushed, as on silicon
	always_ff @(posedge core_clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
		rdData <= mem[rdAddr];
	end
endmodule
`default_nettype wire

// File: bit_skip_clear_call_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"

module bit_skip_clear_call_exec_test;
	import exec_pkg::*;
	// ****************
	// Signals
	// ****************
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic instrValid = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic [7:0] fileRdData = 8'h00;
	logic [7:0] pc_page_latch = 8'h00;
	logic fileWrEn, zeroFlag, watchdogClear, timeout_status_n, powerdown_status_n, flushing;
	logic [6:0] fileWrAddr;
	logic [7:0] fileWrData, accum, rd;
	logic [12:0] pc, stack_top;
	logic [2:0] stackPtr, esp, bn;
	logic [10:0] k;
	logic taken;
	pc_t epc;
	int failures = 0;
	int compares = 0;

	// Instruction-cycle clock, 20 ns
	always #10 core_clk = ~core_clk;

	bit_skip_clear_call_exec bit_skip_clear_call_exec_inst (.core_clk(core_clk), .rst_n(rst_n),
		.instrValid(instrValid), .instr(instr), .fileRdData(fileRdData),
		.pc_page_latch(pc_page_latch), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr),
		.fileWrData(fileWrData), .pc(pc), .accum(accum), .zeroFlag(zeroFlag),
		.stack_top(stack_top), .stackPtr(stackPtr), .watchdogClear(watchdogClear),
		.timeout_status_n(timeout_status_n), .powerdown_status_n(powerdown_status_n),
		.flushing(flushing));

	// ****************
	// Tasks
	// ****************
	// Widened to the widest output so one compare serves all
	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One word per cycle; valid stays up so words run back to back
	task automatic issue(input logic [13:0] w, input logic [7:0] d);
		instr = w;
		fileRdData = d;
		instrValid = 1'b1;
		@(posedge core_clk);
		#1;
	endtask

	task automatic wrap_up;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, far beyond the few dozen cycles of the sequence
	initial
	begin
		#20000;
		failures++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		chk("rst pc", 13'h0000, pc);
		chk("rst top", 13'h0000, stack_top);
		chk("rst accum", 13'h0000, {5'h00, accum});
		chk("rst bits", 13'h0018, {zeroFlag, flushing, fileWrEn, watchdogClear,
			timeout_status_n, powerdown_status_n, stackPtr});
		$display("test reset done");
		epc = 13'h0000;
		esp = 3'h0;
		// Zero flag starts clear, so the accumulator clear must set it
		issue(`OPC_CLEAR_ACCUM_OP_VAL, 8'hFF);
		epc = epc + 13'd1;
		chk("clear_accum_op", 13'h0001, {4'h0, accum, zeroFlag});
		// Reset again mid-run so the file clear has a cleared zero flag to set
		rst_n = 1'b0;
		@(posedge core_clk);
		#1;
		rst_n = 1'b1;
		epc = 13'h0000;
		chk("mid rst", 13'h0000, {11'h000, zeroFlag, flushing});
		chk("mid rst pc", epc, pc);
		// Highest file address
		issue(`OPC_CLEAR_FILE_REG_OP_VAL | 14'h007F, 8'h5A);
		epc = epc + 13'd1;
		chk("clear_file_reg_op ctl", {4'h0, 1'b1, 1'b1, 7'h7F}, {4'h0, fileWrEn, zeroFlag, fileWrAddr});
		chk("clear_file_reg_op data", 13'h0000, {5'h00, fileWrData});
		issue(14'h0000, 8'h00);
		epc = epc + 13'd1;
		chk("clear_file_reg_op pulse", 13'h0000, {12'h000, fileWrEn});
		$display("test clear done");
		// Both skip kinds, both bit values, lowest and highest bit
		for (int i = 0; i < 8; i++)
		begin
			bn = i[2] ? 3'd7 : 3'd0;
			rd = i[1] ? (8'h01 << bn) : ~(8'h01 << bn);
			taken = (i[0] == i[1]);
			issue((i[0] ? `OPC_BIT_SET_VAL : `OPC_BIT_CLR_VAL) | {4'h0, bn, 7'h15}, rd);
			epc = epc + 13'd1;
			chk("skip flush", {12'h000, taken}, {12'h000, flushing});
			chk("skip pc", epc, pc);
			issue(`OPC_CLEAR_FILE_REG_OP_VAL | 14'h0005, 8'h33);
			epc = epc + 13'd1;
			chk("slot write", {12'h000, !taken}, {12'h000, fileWrEn});
			chk("slot pc", epc, pc);
		end
		$display("test skip done");
		// Two calls, latch page bits set then clear with the other bits opposite
		for (int j = 0; j < 2; j++)
		begin
			pc_page_latch = j ? 8'hE7 : 8'h18;
			k = j ? 11'h7FF : 11'h2AA;
			issue(`OPC_CALL_VAL | {3'b000, k}, 8'h00);
			esp = esp + 3'd1;
			chk("call top", epc + 13'd1, stack_top);
			epc = {pc_page_latch[4:3], k};
			chk("call pc", epc, pc);
			chk("call ptr", {10'h000, esp}, {10'h000, stackPtr});
			chk("call flags", 13'h0003, {11'h000, zeroFlag, flushing});
			issue(`OPC_CLEAR_FILE_REG_OP_VAL | 14'h0009, 8'h00);
			epc = epc + 13'd1;
			chk("call slot", 13'h0001, {11'h000, flushing, zeroFlag});
			chk("call slot wr", 13'h0000, {12'h000, fileWrEn});
			chk("call slot pc", epc, pc);
		end
		$display("test call done");
		issue(`OPC_WDTCLR_VAL, 8'h00);
		chk("wdt", 13'h0007, {10'h000, watchdogClear, timeout_status_n, powerdown_status_n});
		issue(14'h0000, 8'h00);
		chk("wdt pulse", 13'h0000, {12'h000, watchdogClear});
		$display("test watchdog done");
		wrap_up();
	end
endmodule
`default_nettype wire
